// [rtl/can_msgbuf_pkg.sv]
// Constants and types shared by the CAN message buffer manager
package can_msgbuf_pkg;
    localparam int NUM_BUF = 11;
    localparam int NUM_FLEX = 6;
    localparam int NUM_FILT = 16;
    localparam int PAY_BYTES = 13;
    localparam logic [3:0] FIRST_TX = 4'h0;
    localparam logic [3:0] FIRST_RX = 4'h3;
    localparam logic [3:0] FIRST_FLEX = 4'h5;
    localparam logic [3:0] LAST_BUF = 4'hA;
    localparam logic [3:0] LEGACY_RX1_FILT = 4'h2;
    localparam logic [3:0] LAST_LINKED_FILT = 4'hD;
    localparam logic [4:0] SDFL_MAX = 5'h12;
    localparam logic [3:0] FIFO_MIN_DEPTH = 4'h2;
    localparam logic [7:0] BUF_AREA_END = 8'hB0;
    localparam logic [3:0] CTRL_BYTE = 4'h0;
    localparam logic [3:0] LAST_BYTE = 4'hD;
    localparam logic [7:0] MODULE_CONTROL_OFS = 8'hC0;
    localparam logic [7:0] MODE_STATUS_OFS = 8'hC1;
    localparam logic [7:0] BUFFER_DIRECTION_OFS = 8'hC2;
    localparam logic [7:0] DATA_FILTER_LEN_OFS = 8'hC3;
    localparam logic [7:0] TX_DONE_FIXED_OFS = 8'hC4;
    localparam logic [7:0] TX_DONE_FLEX_OFS = 8'hC5;
    localparam logic [7:0] TX_DONE_EN_FIXED_OFS = 8'hC6;
    localparam logic [7:0] TX_DONE_EN_FLEX_OFS = 8'hC7;
    localparam logic [7:0] FILTER15_MODE_OFS = 8'hC8;
    localparam logic [7:0] FILTER_LINK_OFS = 8'hD0;
    localparam int MC_CONFIG_BIT = 7;
    localparam int INVALID_MSG_BIT = 7;
    localparam int TXC_ABORTED = 6;
    localparam int TXC_ARB_LOST = 5;
    localparam int TXC_ERROR = 4;
    localparam int TXC_REQUEST = 3;
    localparam int TXC_RTR_EN = 2;
    localparam int RXC_FULL = 7;
    localparam int RXC_RTR = 6;
    localparam logic [7:0] MODULE_CONTROL_RST = 8'h80;
    localparam logic [5:0] DIRECTION_RST = 6'h00;
    localparam logic [5:0] FIXED_LINK_RST = 6'h14;

    typedef enum logic [1:0] {
        FM_LEGACY = 2'b00,
        FM_ENHANCED = 2'b01,
        FM_FIFO = 2'b11
    } fmode_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_BUSY = 2'b01
    } tx_state_t;
endpackage : can_msgbuf_pkg

// [rtl/can_message_buffer_manager.sv]
// Message buffers, functional modes, receive FIFO and transmit scheduling of a CAN controller
// Contract
// - Sixteen filters, two masks, filter 15 as mask
// - Six flexible buffers only in enhanced modes
// - Fourteen filters link to any buffer, mask
// - Standard-id data byte filter, 0 to 18 bits
// - FIFO depth 2..8, ended by first flexible transmit
// - Any linked enabled filter can update FIFO
// - Each buffer fourteen bytes, register mapped
// - Legacy mode: dedicated buffers only
// - Hidden assembly buffer copied only on acceptance
// - Flexible buffers reset receive; direction shapes control byte
// - FIFO access through pointer, no order check
// - Auto reply sets request on matching RTR
// - Pending request makes buffer read-only
// - Setting request clears aborted, arbitration, error
// - Request only marks ready; highest priority sent
// - Success clears request, sets done, interrupts
// - Failure keeps request, notes lost arbitration
// - Transmit error sets flags and interrupts
// - Legacy after reset; mode applied leaving configuration
// - Two-bit priority, ties broken by fixed order
module can_message_buffer_manager
    import can_msgbuf_pkg::*;
(
    input wire logic mclk_i, // 100 MHz module clock
    input wire logic rstn_i, // Async reset, active low
    input wire logic [7:0] addr_i, // Register byte address
    input wire logic [7:0] wdata_i, // Register write data
    input wire logic wr_i, // Write strobe
    input wire logic rd_i, // Read strobe
    output logic [7:0] rdata_o, // Read data, cycle after rd_i
    input wire logic mab_wr_i, // Assembly buffer byte write
    input wire logic [3:0] mab_idx_i, // Assembly byte index 0..12
    input wire logic [7:0] mab_data_i, // Assembly byte value
    input wire logic rx_done_i, // Frame complete and filter matched
    input wire logic [3:0] rx_filter_i, // Number of the matching filter
    input wire logic rx_rtr_i, // Received frame is a remote request
    input wire logic bus_idle_i, // Bus available for start of frame
    input wire logic tx_ok_i, // Current transmission succeeded
    input wire logic tx_arb_lost_i, // Current transmission lost arbitration
    input wire logic tx_error_i, // Current transmission hit an error
    input wire logic [3:0] tx_byte_idx_i, // Payload byte wanted by engine
    output logic tx_start_o, // Start of a transmission, pulse
    output logic [3:0] tx_buf_o, // Buffer being sent
    output logic tx_active_o, // Transmission in progress
    output logic [7:0] tx_byte_o, // Payload byte, one cycle after index
    output logic [1:0] active_mode_o, // Functional mode in force
    output logic filter15_is_mask_o, // Filter 15 serves as third mask
    output logic [4:0] data_filter_len_o, // Data byte filter length in bits
    output logic irq_o // Transmit done or invalid message
);
    logic [7:0] mem [NUM_BUF][PAY_BYTES], next_mem [NUM_BUF][PAY_BYTES];
    logic [7:0] assembly_buffer [PAY_BYTES], next_mab [PAY_BYTES];
    logic [7:0] ctl [NUM_BUF], next_ctl [NUM_BUF];
    logic [5:0] link [NUM_FILT], next_link [NUM_FILT];
    logic config_mode, next_config_mode;
    logic [1:0] mode_req, next_mode_req;
    fmode_t mode, next_mode;
    logic [5:0] direction, next_direction;
    logic [4:0] sdfl, next_sdfl;
    logic filt15_mask, next_filt15_mask;
    logic [NUM_BUF-1:0] done_flag, next_done_flag, done_en, next_done_en;
    logic invalid_flag, next_invalid_flag;
    logic [2:0] fifo_rd, next_fifo_rd, fifo_wr, next_fifo_wr;
    tx_state_t tx_state, next_tx_state;
    logic [3:0] tx_cur, next_tx_cur;
    logic next_tx_start;
    logic [7:0] next_rdata, next_tx_byte;
    logic [3:0] fifo_depth, ready_buf;
    logic ready_any;

    function automatic logic is_tx(input logic [3:0] b, input logic [5:0] dir);
        return (b < FIRST_RX) || (b >= FIRST_FLEX && dir[3'(b - FIRST_FLEX)]);
    endfunction : is_tx
    function automatic logic usable(input logic [3:0] b, input fmode_t m);
        return (b <= LAST_BUF) && ((m != FM_LEGACY) || (b < FIRST_FLEX));
    endfunction : usable
    function automatic logic [3:0] slot_buf(input logic [2:0] s);
        return FIRST_RX + {1'b0, s};
    endfunction : slot_buf
    function automatic logic [2:0] slot_next(input logic [2:0] s, input logic [3:0] depth);
        return ({1'b0, s} + 4'h1 >= depth) ? 3'h0 : s + 3'h1;
    endfunction : slot_next

    // FIFO ends at first flexible transmit buffer
    always_comb
    begin
        logic stop;
        stop = 1'b0;
        fifo_depth = FIFO_MIN_DEPTH;
        for (int i = 0; i < NUM_FLEX; i++)
        begin
            if (direction[i])
                stop = 1'b1;
            else if (!stop)
                fifo_depth = fifo_depth + 4'h1;
        end
    end

    // Later equal priorities win the tie
    always_comb
    begin
        logic [1:0] best;
        logic [3:0] b;
        b = FIRST_TX;
        ready_any = 1'b0;
        ready_buf = FIRST_TX;
        best = 2'b00;
        for (int i = 0; i < NUM_BUF; i++)
        begin
            b = (i < NUM_FLEX) ? FIRST_FLEX + 4'(i) : 4'(i - NUM_FLEX);
            if (usable(b, mode) && is_tx(b, direction) && ctl[b][TXC_REQUEST]
                && (!ready_any || ctl[b][1:0] >= best))
            begin
                ready_any = 1'b1;
                ready_buf = b;
                best = ctl[b][1:0];
            end
        end
    end

    always_comb
    begin
        logic [3:0] hb, hk, tgt, rb;
        logic req_ok;
        next_mem = mem;
        next_mab = assembly_buffer;
        next_ctl = ctl;
        next_link = link;
        next_config_mode = config_mode;
        next_mode_req = mode_req;
        next_mode = mode;
        next_direction = direction;
        next_sdfl = sdfl;
        next_filt15_mask = filt15_mask;
        next_done_flag = done_flag;
        next_done_en = done_en;
        next_invalid_flag = invalid_flag;
        next_fifo_rd = fifo_rd;
        next_fifo_wr = fifo_wr;
        next_tx_state = tx_state;
        next_tx_cur = tx_cur;
        next_tx_start = 1'b0;
        next_rdata = 8'h00;
        hb = addr_i[7:4];
        hk = addr_i[3:0];
        tgt = FIRST_RX;
        rb = FIRST_RX;
        req_ok = 1'b0;

        // Reads see state before this cycle's changes
        if (rd_i)
        begin
            if (addr_i < BUF_AREA_END)
            begin
                if (usable(hb, mode) && hk <= LAST_BYTE)
                begin
                    if (hk != CTRL_BYTE)
                        next_rdata = mem[hb][hk - 4'h1];
                    else if (is_tx(hb, direction))
                        next_rdata = {1'b0, ctl[hb][6:0]};
                    else
                        next_rdata = {ctl[hb][7:6], 1'b0, ctl[hb][4:0]};
                end
            end
            else
            begin
                unique case (addr_i)
                    MODULE_CONTROL_OFS:
                        next_rdata = {config_mode, mode_req, slot_buf(fifo_rd) + 5'h00};
                    MODE_STATUS_OFS: next_rdata = {2'b00, fifo_depth, mode};
                    BUFFER_DIRECTION_OFS: next_rdata = {2'b00, direction};
                    DATA_FILTER_LEN_OFS: next_rdata = {3'b000, sdfl};
                    TX_DONE_FIXED_OFS: next_rdata = {invalid_flag, 4'h0, done_flag[2:0]};
                    TX_DONE_FLEX_OFS: next_rdata = {2'b00, done_flag[10:5]};
                    TX_DONE_EN_FIXED_OFS: next_rdata = {5'h00, done_en[2:0]};
                    TX_DONE_EN_FLEX_OFS: next_rdata = {2'b00, done_en[10:5]};
                    FILTER15_MODE_OFS: next_rdata = {7'h00, filt15_mask};
                    default:
                        if (addr_i[7:4] == FILTER_LINK_OFS[7:4])
                            next_rdata = {2'b00, link[hk]};
                endcase
            end
        end

        // Pending request locks the buffer
        if (wr_i)
        begin
            if (addr_i < BUF_AREA_END)
            begin
                if (usable(hb, mode) && hk <= LAST_BYTE && !ctl[hb][TXC_REQUEST])
                begin
                    if (hk != CTRL_BYTE)
                        next_mem[hb][hk - 4'h1] = wdata_i;
                    else if (is_tx(hb, direction))
                    begin
                        next_ctl[hb][1:0] = wdata_i[1:0];
                        next_ctl[hb][TXC_RTR_EN] = (hb >= FIRST_FLEX) && wdata_i[TXC_RTR_EN];
                        if (wdata_i[TXC_REQUEST])
                            next_ctl[hb][TXC_ABORTED:TXC_REQUEST] = 4'h1;
                    end
                    else if (!wdata_i[RXC_FULL] && ctl[hb][RXC_FULL])
                    begin
                        next_ctl[hb][RXC_FULL] = 1'b0;
                        if (mode == FM_FIFO && hb == slot_buf(fifo_rd))
                            next_fifo_rd = slot_next(fifo_rd, fifo_depth);
                    end
                end
            end
            else
            begin
                unique case (addr_i)
                    MODULE_CONTROL_OFS:
                    begin
                        next_config_mode = wdata_i[MC_CONFIG_BIT];
                        if (config_mode)
                            next_mode_req = wdata_i[6:5];
                        if (config_mode && !wdata_i[MC_CONFIG_BIT])
                        begin
                            next_mode = (mode_req == FM_ENHANCED || mode_req == FM_FIFO)
                                ? fmode_t'(mode_req) : FM_LEGACY;
                            next_fifo_rd = 3'h0;
                            next_fifo_wr = 3'h0;
                        end
                    end
                    BUFFER_DIRECTION_OFS: next_direction = wdata_i[5:0];
                    DATA_FILTER_LEN_OFS:
                        if (config_mode)
                            next_sdfl = (wdata_i[4:0] > SDFL_MAX) ? SDFL_MAX : wdata_i[4:0];
                    TX_DONE_FIXED_OFS:
                    begin
                        next_done_flag[2:0] = done_flag[2:0] & ~wdata_i[2:0];
                        next_invalid_flag = invalid_flag & ~wdata_i[INVALID_MSG_BIT];
                    end
                    TX_DONE_FLEX_OFS: next_done_flag[10:5] = done_flag[10:5] & ~wdata_i[5:0];
                    TX_DONE_EN_FIXED_OFS: next_done_en[2:0] = wdata_i[2:0];
                    TX_DONE_EN_FLEX_OFS: next_done_en[10:5] = wdata_i[5:0];
                    FILTER15_MODE_OFS:
                        if (config_mode)
                            next_filt15_mask = wdata_i[0];
                    default:
                        if (addr_i[7:4] == FILTER_LINK_OFS[7:4] && config_mode
                            && hk <= LAST_LINKED_FILT)
                            next_link[hk] = wdata_i[5:0];
                endcase
            end
        end

        // Hidden assembly buffer; host has no path to it
        if (mab_wr_i && mab_idx_i < 4'(PAY_BYTES))
            next_mab[mab_idx_i] = mab_data_i;

        // Acceptance: only a matched frame moves the assembly buffer on
        if (rx_done_i)
        begin
            tgt = (mode != FM_LEGACY) ? link[rx_filter_i][3:0]
                : (rx_filter_i < LEGACY_RX1_FILT) ? FIRST_RX : FIRST_RX + 4'h1;
            if (usable(tgt, mode) && is_tx(tgt, direction))
            begin
                if (rx_rtr_i && ctl[tgt][TXC_RTR_EN] && !ctl[tgt][TXC_REQUEST])
                    next_ctl[tgt][TXC_ABORTED:TXC_REQUEST] = 4'h1;
            end
            else if (mode == FM_FIFO)
            begin
                rb = slot_buf(fifo_wr);
                if (tgt >= FIRST_RX && tgt < FIRST_RX + fifo_depth && !ctl[rb][RXC_FULL])
                begin
                    req_ok = 1'b1;
                    next_fifo_wr = slot_next(fifo_wr, fifo_depth);
                end
            end
            else if (usable(tgt, mode) && !ctl[tgt][RXC_FULL])
            begin
                rb = tgt;
                req_ok = 1'b1;
            end
            if (req_ok)
            begin
                next_mem[rb] = assembly_buffer;
                next_ctl[rb] = {1'b1, rx_rtr_i, 1'b0, 1'b0, rx_filter_i}; // Set beats release
            end
        end

        // Transmit scheduling
        unique case (tx_state)
            TX_IDLE:
                if (bus_idle_i && ready_any && !config_mode)
                begin
                    next_tx_state = TX_BUSY;
                    next_tx_cur = ready_buf;
                    next_tx_start = 1'b1;
                end
            TX_BUSY:
                if (tx_ok_i)
                begin
                    next_ctl[tx_cur][TXC_REQUEST] = 1'b0;
                    next_done_flag[tx_cur] = 1'b1;
                    next_tx_state = TX_IDLE;
                end
                else if (tx_arb_lost_i)
                begin
                    next_ctl[tx_cur][TXC_ARB_LOST] = 1'b1;
                    next_tx_state = TX_IDLE;
                end
                else if (tx_error_i)
                begin
                    next_ctl[tx_cur][TXC_ERROR] = 1'b1;
                    next_invalid_flag = 1'b1;
                    next_tx_state = TX_IDLE;
                end
        endcase

        next_tx_byte = (tx_byte_idx_i < 4'(PAY_BYTES)) ? mem[tx_cur][tx_byte_idx_i] : 8'h00;
    end

    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            ctl <= '{default: 8'h00};
            mem <= '{default: 8'h00};
            assembly_buffer <= '{default: 8'h00};
            link <= '{default: FIXED_LINK_RST};
            config_mode <= MODULE_CONTROL_RST[MC_CONFIG_BIT];
            mode_req <= 2'b00;
            mode <= FM_LEGACY;
            direction <= DIRECTION_RST;
            sdfl <= 5'h00;
            filt15_mask <= 1'b0;
            done_flag <= '0;
            done_en <= '0;
            invalid_flag <= 1'b0;
            fifo_rd <= 3'h0;
            fifo_wr <= 3'h0;
            tx_state <= TX_IDLE;
            tx_cur <= 4'h0;
            tx_start_o <= 1'b0;
            rdata_o <= 8'h00;
            tx_byte_o <= 8'h00;
        end
        else
        begin
            mem <= next_mem;
            assembly_buffer <= next_mab;
            ctl <= next_ctl;
            link <= next_link;
            config_mode <= next_config_mode;
            mode_req <= next_mode_req;
            mode <= next_mode;
            direction <= next_direction;
            sdfl <= next_sdfl;
            filt15_mask <= next_filt15_mask;
            done_flag <= next_done_flag;
            done_en <= next_done_en;
            invalid_flag <= next_invalid_flag;
            fifo_rd <= next_fifo_rd;
            fifo_wr <= next_fifo_wr;
            tx_state <= next_tx_state;
            tx_cur <= next_tx_cur;
            tx_start_o <= next_tx_start;
            rdata_o <= next_rdata;
            tx_byte_o <= next_tx_byte;
        end
    end

    assign tx_buf_o = tx_cur;
    assign tx_active_o = (tx_state == TX_BUSY);
    assign active_mode_o = mode;
    assign filter15_is_mask_o = filt15_mask;
    assign data_filter_len_o = sdfl;
    assign irq_o = |(done_flag & done_en) | invalid_flag;
endmodule : can_message_buffer_manager

// [dv/can_msgbuf_props.sv]
// Checker of transmit scheduling, mode switching and read timing
module can_msgbuf_props
    import can_msgbuf_pkg::*;
(
    input wire logic mclk_i, // Clock
    input wire logic rstn_i, // Reset, active low
    input wire logic [7:0] addr_i, // Address
    input wire logic wr_i, // Write strobe
    input wire logic rd_i, // Read strobe
    input wire logic [7:0] rdata_o, // Read data
    input wire logic bus_idle_i, // Bus free
    input wire logic tx_ok_i, // Success
    input wire logic tx_arb_lost_i, // Arbitration lost
    input wire logic tx_error_i, // Error
    input wire logic tx_start_o, // Start pulse
    input wire logic [3:0] tx_buf_o, // Buffer sent
    input wire logic tx_active_o, // Busy
    input wire logic [1:0] active_mode_o, // Mode in force
    input wire logic [4:0] data_filter_len_o // Data filter length
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rstn_i);
    sequence s_launch;
        !tx_active_o && bus_idle_i ##1 tx_start_o;
    endsequence
    sequence s_result;
        tx_active_o && (tx_ok_i || tx_arb_lost_i || tx_error_i);
    endsequence
    AST_START_CAUSE: assert property ($rose(tx_active_o) |-> $past(bus_idle_i) && tx_start_o)
        else $error("transmission began without a free bus");
    AST_LAUNCH: assert property (s_launch |-> tx_active_o ##1 !tx_start_o)
        else $error("start pulse malformed");
    AST_END: assert property (s_result |=> !tx_active_o)
        else $error("transmission did not end on its result");
    AST_HOLD_BUF: assert property (tx_active_o && !tx_start_o |-> $stable(tx_buf_o))
        else $error("buffer number moved mid frame");
    AST_TX_BUF: assert property (tx_active_o |->
        (tx_buf_o < FIRST_RX || tx_buf_o >= FIRST_FLEX) && tx_buf_o <= LAST_BUF)
        else $error("receive or unknown buffer sent");
    AST_LEGACY_TX: assert property (tx_start_o && active_mode_o == FM_LEGACY |->
        tx_buf_o < FIRST_RX)
        else $error("flexible buffer sent in legacy mode");
    AST_RDATA_IDLE: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside its cycle");
    AST_MODE_WRITE: assert property ($changed(active_mode_o) |->
        $past(wr_i) && $past(addr_i) == MODULE_CONTROL_OFS)
        else $error("mode changed without control write");
    AST_MODE_CODE: assert property (active_mode_o != 2'b10)
        else $error("illegal mode code");
    AST_DFL_RANGE: assert property (data_filter_len_o <= SDFL_MAX)
        else $error("data filter length above maximum");
endmodule : can_msgbuf_props

bind can_message_buffer_manager can_msgbuf_props u_props (.mclk_i, .rstn_i, .addr_i, .wr_i,
    .rd_i, .rdata_o, .bus_idle_i, .tx_ok_i, .tx_arb_lost_i, .tx_error_i, .tx_start_o, .tx_buf_o,
    .tx_active_o, .active_mode_o, .data_filter_len_o);

// [dv/can_bus_node_model.sv]
// Far side: other bus nodes answering the block's frames
module can_bus_node_model
(
    input wire logic mclk_i, // Clock
    input wire logic rstn_i, // Reset, active low
    input wire logic busy_i, // Another node holds the bus
    input wire logic [1:0] res_i, // Outcome: 0 ok, 1 arbitration, 2 error
    input wire logic tx_active_i, // Frame running
    input wire logic [7:0] tx_byte_i, // Payload byte from block
    output logic bus_idle_o, // Bus free
    output logic ok_o, // Success pulse
    output logic arb_o, // Arbitration lost pulse
    output logic err_o, // Error pulse
    output logic [3:0] idx_o // Payload byte wanted
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got [0:15];
    logic [3:0] cnt;
    logic [2:0] gap;
    // Intermission keeps a retry from racing the bench
    assign bus_idle_o = !busy_i && gap == 3'h7;
    assign idx_o = cnt;
    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            cnt <= 4'h0;
            gap <= 3'h7;
            {ok_o, arb_o, err_o} <= 3'b000;
        end
        else
        begin
            cnt <= !tx_active_i ? 4'h0 : (cnt == 4'hF ? cnt : cnt + 4'h1);
            gap <= tx_active_i ? 3'h0 : (gap == 3'h7 ? gap : gap + 3'h1);
            got[cnt - 4'h1] <= tx_byte_i;
            ok_o <= tx_active_i && cnt == 4'hE && res_i == 2'h0;
            arb_o <= tx_active_i && cnt == 4'hE && res_i == 2'h1;
            err_o <= tx_active_i && cnt == 4'hE && res_i == 2'h2;
        end
    end
endmodule : can_bus_node_model

// [dv/can_message_buffer_manager_test.sv]
// Self-checking bench of the CAN message buffer manager
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
    $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module can_message_buffer_manager_test;
    import can_msgbuf_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 0, rstn_i = 0, wr_i = 0, rd_i = 0, mab_wr_i = 0, rx_done_i = 0, rx_rtr_i = 0;
    logic busy = 1;
    logic [7:0] addr_i = 0, wdata_i = 0, mab_data_i = 0, rdata_o, tx_byte_o, v;
    logic [3:0] mab_idx_i = 0, rx_filter_i = 0, tx_byte_idx_i, tx_buf_o;
    logic [1:0] res = 0, active_mode_o;
    logic bus_idle_i, tx_ok_i, tx_arb_lost_i, tx_error_i, tx_start_o, tx_active_o;
    logic filter15_is_mask_o, irq_o;
    logic [4:0] data_filter_len_o;
    logic [5:0] d;
    logic [7:0] pay [0:12];
    int n_fail = 0, checked = 0, seed = 61856, r;
    int order[$];
    int exp_ord[3] = '{0, 2, 1};
    can_message_buffer_manager uut (.mclk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .mab_wr_i, .mab_idx_i, .mab_data_i, .rx_done_i, .rx_filter_i, .rx_rtr_i, .bus_idle_i,
        .tx_ok_i, .tx_arb_lost_i, .tx_error_i, .tx_byte_idx_i, .tx_start_o, .tx_buf_o,
        .tx_active_o, .tx_byte_o, .active_mode_o, .filter15_is_mask_o, .data_filter_len_o, .irq_o);
    can_bus_node_model node (.mclk_i, .rstn_i, .busy_i(busy), .res_i(res), .tx_active_i(tx_active_o),
        .tx_byte_i(tx_byte_o), .bus_idle_o(bus_idle_i), .ok_o(tx_ok_i), .arb_o(tx_arb_lost_i),
        .err_o(tx_error_i), .idx_o(tx_byte_idx_i));
    initial forever #5 mclk_i = ~mclk_i;
    always @(posedge mclk_i) if (tx_start_o) order.push_back(tx_buf_o);
    function automatic logic [3:0] exp_depth(input logic [5:0] dir);
        for (int p = 0; p < 6; p++) if (dir[p]) return 4'(2 + p);
        return 4'h8;
    endfunction : exp_depth
    task automatic wr(input logic [7:0] a, input logic [7:0] dv);
        @(posedge mclk_i);
        {addr_i, wdata_i, wr_i} <= {a, dv, 1'b1};
        @(posedge mclk_i);
        wr_i <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge mclk_i);
        {addr_i, rd_i} <= {a, 1'b1};
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 v = rdata_o;
    endtask : rd
    task automatic frame(input logic [3:0] f, input logic rtr, input logic go);
        for (int i = 0; i < 13; i++)
        begin
            @(posedge mclk_i);
            {mab_wr_i, mab_idx_i, mab_data_i} <= {1'b1, 4'(i), pay[i]};
        end
        @(posedge mclk_i);
        {mab_wr_i, rx_done_i, rx_filter_i, rx_rtr_i} <= {1'b0, go, f, rtr};
        @(posedge mclk_i);
        rx_done_i <= 1'b0;
        #1;
    endtask : frame
    task automatic wait_tx(input int n);
        for (int k = 0; k < 400; k++)
        begin
            @(posedge mclk_i);
            #1;
            if (order.size() >= n && !tx_active_o) break;
        end
        busy <= 1'b1;
    endtask : wait_tx
    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        #400000;
        n_fail++;
        tally_and_finish();
    end
    initial
    begin
        repeat (16) @(posedge mclk_i);
        rstn_i <= 1'b1;
        rd(MODULE_CONTROL_OFS); `CHK(v, MODULE_CONTROL_RST | 8'(FIRST_RX))
        rd(BUFFER_DIRECTION_OFS); `CHK(v[5:0], DIRECTION_RST)
        wr(DATA_FILTER_LEN_OFS, 8'h1F); `CHK(data_filter_len_o, SDFL_MAX)
        r = {$random(seed)} % 19;
        wr(DATA_FILTER_LEN_OFS, 8'(r)); `CHK(data_filter_len_o, 5'(r))
        wr(FILTER15_MODE_OFS, 8'h01); `CHK(filter15_is_mask_o, 1'b1)
        wr(8'h51, 8'h5A); rd(8'h51); `CHK(v, 8'h00)
        foreach (pay[i]) pay[i] = 8'($random(seed));
        frame(4'h1, 1'b0, 1'b0); rd(8'h36); `CHK(v, 8'h00)
        frame(4'h1, 1'b0, 1'b1); rd(8'h30); `CHK(v, 8'h81)
        rd(8'h36); `CHK(v, pay[5])
        rd(8'h3D); `CHK(v, pay[12])
        rd(8'h3E); `CHK(v, 8'h00)
        frame(4'h3, 1'b0, 1'b1); rd(8'h40); `CHK(v, 8'h83)
        wr(8'h30, 8'h00);
        wr(8'h40, 8'h00);
        wr(MODULE_CONTROL_OFS, 8'h00);
        wr(TX_DONE_EN_FIXED_OFS, 8'h07);
        wr(8'h01, 8'hA5);
        wr(8'h00, 8'h0B);
        wr(8'h10, 8'h09);
        wr(8'h20, 8'h09);
        wr(8'h01, 8'h3C); rd(8'h01); `CHK(v, 8'hA5)
        `CHK(order.size(), 0)
        busy <= 1'b0;
        wait_tx(3);
        for (int k = 0; k < 3; k++) `CHK(order[k], exp_ord[k])
        rd(8'h00); `CHK(v[3], 1'b0)
        rd(TX_DONE_FIXED_OFS); `CHK(v[2:0], 3'h7)
        `CHK(irq_o, 1'b1)
        wr(TX_DONE_FIXED_OFS, 8'h07); `CHK(irq_o, 1'b0)
        order.delete();
        res <= 2'h2;
        wr(8'h00, 8'h0B);
        busy <= 1'b0;
        wait_tx(1);
        rd(8'h00); `CHK(v[4:3], 2'b11)
        rd(TX_DONE_FIXED_OFS); `CHK(v[7], 1'b1)
        res <= 2'h1;
        busy <= 1'b0;
        wait_tx(2);
        rd(8'h00); `CHK(v[5:3], 3'b111)
        res <= 2'h0;
        busy <= 1'b0;
        wait_tx(3);
        wr(8'h00, 8'h08); rd(8'h00); `CHK(v[6:3], 4'b0001)
        busy <= 1'b0;
        wait_tx(4);
        for (int k = 0; k < 6; k++)
        begin
            d = k ? 6'($random(seed)) : 6'h3F;
            wr(MODULE_CONTROL_OFS, 8'h80);
            wr(MODULE_CONTROL_OFS, 8'hE0); `CHK(active_mode_o, k ? FM_FIFO : FM_LEGACY)
            wr(BUFFER_DIRECTION_OFS, {2'b00, d});
            wr(MODULE_CONTROL_OFS, 8'h60);
            rd(MODE_STATUS_OFS); `CHK(v[5:2], exp_depth(d))
        end
        wr(MODULE_CONTROL_OFS, 8'h80);
        wr(BUFFER_DIRECTION_OFS, 8'h00);
        wr(8'hD5, 8'h03);
        wr(MODULE_CONTROL_OFS, 8'h60);
        rd(MODULE_CONTROL_OFS); `CHK(v[4:0], 5'h03)
        frame(4'h5, 1'b0, 1'b1);
        frame(4'h5, 1'b0, 1'b1); rd(8'h40); `CHK(v[7], 1'b1)
        wr(8'h30, 8'h00); rd(MODULE_CONTROL_OFS); `CHK(v[4:0], 5'h04)
        wr(MODULE_CONTROL_OFS, 8'h80);
        wr(MODULE_CONTROL_OFS, 8'hA0);
        wr(BUFFER_DIRECTION_OFS, 8'h01);
        wr(8'hD7, 8'h05);
        wr(MODULE_CONTROL_OFS, 8'h20); `CHK(active_mode_o, FM_ENHANCED)
        wr(8'h56, 8'hC3);
        wr(8'h50, 8'h04); rd(8'h50); `CHK(v, 8'h04)
        order.delete();
        frame(4'h7, 1'b1, 1'b1); rd(8'h50); `CHK(v[3], 1'b1)
        wr(8'h56, 8'h11); rd(8'h56); `CHK(v, 8'hC3)
        busy <= 1'b0;
        wait_tx(1); `CHK(order[0], 5)
        `CHK(node.got[5], 8'hC3)
        rstn_i <= 1'b0;
        repeat (2) @(posedge mclk_i); `CHK(active_mode_o, FM_LEGACY)
        rstn_i <= 1'b1;
        rd(BUFFER_DIRECTION_OFS); `CHK(v[5:0], DIRECTION_RST)
        tally_and_finish();
    end
endmodule : can_message_buffer_manager_test
